// ===== common/cse_map.vh
// cse_map.vh: register map, field positions, reset values and timing
// for the charger status, event and mask block.
// assumes a 25 MHz core clock; include by bare name.
`ifndef CSE_MAP_VH
`define CSE_MAP_VH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define CSE_OFS_STATUS_SUPPLY   8'h00
`define CSE_OFS_STATUS_PROT     8'h01
`define CSE_OFS_EVENT_SUPPLY    8'h02
`define CSE_OFS_EVENT_PROT      8'h03
`define CSE_OFS_EVENT_TIMERS    8'h04
`define CSE_OFS_MASK_SUPPLY     8'h05
`define CSE_OFS_MASK_PROT       8'h06
`define CSE_OFS_MASK_TIMERS     8'h07
`define CSE_OFS_ADC_CONTROL     8'h0E

// ---------------------------------------------------------------------
// field layout
// ---------------------------------------------------------------------
`define CSE_SUPPLY_LSB          3
`define CSE_STATE_MSB           2
`define CSE_TIMERS_USED         8'h1F
`define CSE_BIT_ADC_DONE        4
`define CSE_BIT_SAFETY          3
`define CSE_BIT_SOFT_TIMER      2
`define CSE_BIT_PEAK            1
`define CSE_BIT_POWERON         0
`define CSE_BIT_SINGLE_CONV     0

// ---------------------------------------------------------------------
// operating state codes
// ---------------------------------------------------------------------
`define CSE_STATE_SHUTDOWN      3'h0
`define CSE_STATE_IDLE          3'h1
`define CSE_STATE_LOW_POWER     3'h2
`define CSE_STATE_ACTIVE        3'h4

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define CSE_RST_MASK_SUPPLY     8'hF0
`define CSE_RST_MASK_PROT       8'hFF
`define CSE_RST_MASK_TIMERS     8'h1F
`define CSE_RST_EVENT           8'h00

// ---------------------------------------------------------------------
// 2-wire interface and timing
// ---------------------------------------------------------------------
`define CSE_DEV_ADDR            7'h59
`define CSE_CLOCK_NS            40
`define CSE_PEAK_FILTER_NS      1000
`define CSE_PEAK_FILTER_CYC     ((`CSE_PEAK_FILTER_NS) / (`CSE_CLOCK_NS))

`endif

// ===== verilog/cse_sync_filter.v
// cse_sync_filter.v: three-stage synchroniser with agreement filter.
// assumes inputs asynchronous to i_clock; output moves once stages
// two and three agree.
`timescale 1ns/1ps
`default_nettype none

module cse_sync_filter #(
   parameter       WIDTH = 1,
   parameter [31:0] INIT = 32'h0000_0000
)(
   input  wire             i_clock,
   input  wire             i_rst_b,
   input  wire [WIDTH-1:0] i_async,
   output reg  [WIDTH-1:0] o_level
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;
   reg [WIDTH-1:0] stage3_r;

   // ------------------------------------------------------------------
   // synchroniser chain and filtered output
   // ------------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         stage1_r <= INIT[WIDTH-1:0];
         stage2_r <= INIT[WIDTH-1:0];
         stage3_r <= INIT[WIDTH-1:0];
         o_level  <= INIT[WIDTH-1:0];
      end
      else
      begin
         stage1_r <= i_async;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         // per bit: take the value only where stages two and three agree
         o_level  <= (stage2_r & ~(stage2_r ^ stage3_r))
                   | (o_level & (stage2_r ^ stage3_r));
      end
   end

endmodule

`default_nettype wire

// ===== verilog/cse_status_event.v
// cse_status_event.v: status, event latch and interrupt mask block with
// its 2-wire register slave.
// assumes comparator flags and pins are asynchronous; state code and
// event pulses come from logic on i_clock.
`timescale 1ns/1ps
`default_nettype none
`include "cse_map.vh"

module cse_status_event (
   input  wire       i_clock,
   input  wire       i_rst_b,
   input  wire       i_scl,
   input  wire       i_sda,
   output reg        o_sda_oe,
   output wire       o_sda_out,
   input  wire [4:0] i_supply_flags,
   input  wire [7:0] i_prot_flags,
   input  wire       i_peak_over,
   input  wire [2:0] i_op_state,
   input  wire       i_adc_done,
   input  wire       i_safety_expired,
   input  wire       i_soft_timer_expired,
   input  wire       i_temp_poweron,
   output reg        o_adc_start,
   output reg        o_irq
);

   // ------------------------------------------------------------------
   // state codes of the 2-wire slave
   // ------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_REG  = 3'd2;
   localparam [2:0] ST_WDAT = 3'd3;
   localparam [2:0] ST_RDAT = 3'd4;
   localparam [2:0] ST_ACK  = 3'd5;
   localparam [2:0] ST_RACK = 3'd6;
   localparam integer PEAK_CYC_I = `CSE_PEAK_FILTER_CYC;
   localparam [7:0]   PEAK_CYC   = PEAK_CYC_I[7:0];

   wire       scl;
   wire       sda;
   wire [4:0] supply;
   wire [7:0] prot;
   wire       peak;
   reg        scl_d_r;
   reg        sda_d_r;
   reg  [2:0] st_r;
   reg  [2:0] after_ack_r;
   reg  [3:0] bit_cnt_r;
   reg  [7:0] shift_r;
   reg  [7:0] ptr_r;
   reg  [7:0] tx_r;
   reg        wr_stb_r;
   reg  [7:0] wr_data_r;
   reg  [2:0] state_r;
   reg  [4:0] supply_d_r;
   reg  [7:0] prot_d_r;
   reg  [7:0] ev_sup_r;
   reg  [7:0] ev_prot_r;
   reg  [7:0] ev_tim_r;
   reg  [7:0] mask_sup_r;
   reg  [7:0] mask_prot_r;
   reg  [7:0] mask_tim_r;
   reg  [7:0] peak_cnt_r;
   reg        peak_fired_r;
   reg  [7:0] ev_sup_nxt;
   reg  [7:0] ev_prot_nxt;
   reg  [7:0] ev_tim_nxt;
   reg  [7:0] set_tim;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_c;
   wire       stop_c;

   // ------------------------------------------------------------------
   // register read mux, shared by first and follow-on read bytes
   // ------------------------------------------------------------------
   function [7:0] rd_mux;
      input [7:0] ofs;
      begin
         case (ofs)
            `CSE_OFS_STATUS_SUPPLY: rd_mux = {supply_d_r, state_r};
            `CSE_OFS_STATUS_PROT:   rd_mux = prot_d_r;
            `CSE_OFS_EVENT_SUPPLY:  rd_mux = ev_sup_r;
            `CSE_OFS_EVENT_PROT:    rd_mux = ev_prot_r;
            `CSE_OFS_EVENT_TIMERS:  rd_mux = ev_tim_r;
            `CSE_OFS_MASK_SUPPLY:   rd_mux = mask_sup_r;
            `CSE_OFS_MASK_PROT:     rd_mux = mask_prot_r;
            `CSE_OFS_MASK_TIMERS:   rd_mux = mask_tim_r;
            default:                rd_mux = 8'h00;
         endcase
      end
   endfunction

   // write-one-to-clear with set winning over clear
   function [7:0] w1c;
      input [7:0] cur;
      input [7:0] set;
      input       hit;
      input [7:0] data;
      begin
         w1c = (cur & ~(hit ? data : 8'h00)) | set;
      end
   endfunction

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   cse_sync_filter #(.WIDTH(2), .INIT(32'h0000_0003)) u_pins (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_async ({i_scl, i_sda}),
      .o_level ({scl, sda})
   );

   cse_sync_filter #(.WIDTH(14), .INIT(32'h0000_0000)) u_flags (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_async ({i_supply_flags, i_prot_flags, i_peak_over}),
      .o_level ({supply, prot, peak})
   );

   // bus edges and start or stop conditions
   assign scl_rise  = scl & ~scl_d_r;
   assign scl_fall  = ~scl & scl_d_r;
   assign start_c   = scl & scl_d_r & sda_d_r & ~sda;
   assign stop_c    = scl & scl_d_r & ~sda_d_r & sda;
   assign o_sda_out = 1'b0;

   // ------------------------------------------------------------------
   // 2-wire slave: address, register pointer, data bytes
   // ------------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         scl_d_r     <= 1'b1;
         sda_d_r     <= 1'b1;
         st_r        <= ST_IDLE;
         after_ack_r <= ST_IDLE;
         bit_cnt_r   <= 4'h0;
         shift_r     <= 8'h00;
         ptr_r       <= 8'h00;
         tx_r        <= 8'h00;
         o_sda_oe    <= 1'b0;
         wr_stb_r    <= 1'b0;
         wr_data_r   <= 8'h00;
      end
      else
      begin
         scl_d_r  <= scl;
         sda_d_r  <= sda;
         wr_stb_r <= 1'b0;
         if (wr_stb_r) // pointer steps after each written byte
            ptr_r <= ptr_r + 8'h01;
         if (start_c)
         begin
            st_r      <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            o_sda_oe  <= 1'b0;
         end
         else if (stop_c)
         begin
            st_r     <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end
         else if (scl_rise)
         begin
            case (st_r)
               ST_ADDR, ST_REG, ST_WDAT:
               begin
                  shift_r   <= {shift_r[6:0], sda};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               ST_RDAT:
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               ST_RACK:
                  if (sda)
                     st_r <= ST_IDLE; // master refused more data
               default:
                  st_r <= st_r;
            endcase
         end
         else if (scl_fall)
         begin
            case (st_r)
               ST_ADDR:
                  if (bit_cnt_r == 4'h8)
                  begin
                     if (shift_r[7:1] == `CSE_DEV_ADDR)
                     begin
                        o_sda_oe    <= 1'b1;
                        st_r        <= ST_ACK;
                        after_ack_r <= shift_r[0] ? ST_RDAT : ST_REG;
                        tx_r        <= rd_mux(ptr_r);
                     end
                     else
                        st_r <= ST_IDLE;
                  end
               ST_REG:
                  if (bit_cnt_r == 4'h8)
                  begin
                     ptr_r       <= shift_r;
                     o_sda_oe    <= 1'b1;
                     st_r        <= ST_ACK;
                     after_ack_r <= ST_WDAT;
                  end
               ST_WDAT:
                  if (bit_cnt_r == 4'h8)
                  begin
                     wr_stb_r    <= 1'b1;
                     wr_data_r   <= shift_r;
                     o_sda_oe    <= 1'b1;
                     st_r        <= ST_ACK;
                     after_ack_r <= ST_WDAT;
                  end
               ST_ACK:
               begin
                  bit_cnt_r <= 4'h0;
                  st_r      <= after_ack_r;
                  o_sda_oe  <= (after_ack_r == ST_RDAT) ? ~tx_r[7] : 1'b0;
               end
               ST_RDAT:
                  if (bit_cnt_r == 4'h8)
                  begin
                     o_sda_oe <= 1'b0;
                     st_r     <= ST_RACK;
                  end
                  else
                     o_sda_oe <= ~tx_r[3'd7 - bit_cnt_r[2:0]];
               ST_RACK:
               begin
                  ptr_r     <= ptr_r + 8'h01;
                  tx_r      <= rd_mux(ptr_r + 8'h01);
                  o_sda_oe  <= ~|(rd_mux(ptr_r + 8'h01) & 8'h80);
                  bit_cnt_r <= 4'h0;
                  st_r      <= ST_RDAT;
               end
               default:
                  st_r <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // event set terms and write-one-to-clear
   // ------------------------------------------------------------------
   always @*
   begin
      set_tim = 8'h00;
      set_tim[`CSE_BIT_ADC_DONE]   = i_adc_done;
      set_tim[`CSE_BIT_SAFETY]     = i_safety_expired;
      set_tim[`CSE_BIT_SOFT_TIMER] = i_soft_timer_expired;
      set_tim[`CSE_BIT_PEAK]       = peak & ~peak_fired_r
                                     & (peak_cnt_r > PEAK_CYC);
      set_tim[`CSE_BIT_POWERON]    = i_temp_poweron;
      ev_sup_nxt  = w1c(ev_sup_r, {supply ^ supply_d_r, 3'b000},
                        wr_stb_r && ptr_r == `CSE_OFS_EVENT_SUPPLY,
                        wr_data_r);
      ev_prot_nxt = w1c(ev_prot_r, prot ^ prot_d_r,
                        wr_stb_r && ptr_r == `CSE_OFS_EVENT_PROT,
                        wr_data_r);
      ev_tim_nxt  = w1c(ev_tim_r, set_tim,
                        wr_stb_r && ptr_r == `CSE_OFS_EVENT_TIMERS,
                        wr_data_r & `CSE_TIMERS_USED & 8'hFE);
   end

   // ------------------------------------------------------------------
   // status, events, masks, peak filter, interrupt and ADC trigger
   // ------------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         state_r      <= `CSE_STATE_SHUTDOWN;
         supply_d_r   <= 5'h00;
         prot_d_r     <= 8'h00;
         ev_sup_r     <= `CSE_RST_EVENT;
         ev_prot_r    <= `CSE_RST_EVENT;
         ev_tim_r     <= `CSE_RST_EVENT;
         mask_sup_r   <= `CSE_RST_MASK_SUPPLY;
         mask_prot_r  <= `CSE_RST_MASK_PROT;
         mask_tim_r   <= `CSE_RST_MASK_TIMERS;
         peak_cnt_r   <= 8'h00;
         peak_fired_r <= 1'b0;
         o_adc_start  <= 1'b0;
         o_irq        <= 1'b0;
      end
      else
      begin
         // reserved and undefined codes keep the last reported state
         case (i_op_state)
            `CSE_STATE_SHUTDOWN, `CSE_STATE_IDLE,
            `CSE_STATE_LOW_POWER, `CSE_STATE_ACTIVE:
               state_r <= i_op_state;
            default:
               state_r <= state_r;
         endcase
         supply_d_r <= supply;
         prot_d_r   <= prot;
         ev_sup_r   <= ev_sup_nxt;
         ev_prot_r  <= ev_prot_nxt;
         ev_tim_r   <= ev_tim_nxt;
         // peak-limit dwell counter, one event per episode
         if (!peak)
         begin
            peak_cnt_r   <= 8'h00;
            peak_fired_r <= 1'b0;
         end
         else
         begin
            if (peak_cnt_r <= PEAK_CYC)
               peak_cnt_r <= peak_cnt_r + 8'h01;
            if (peak_cnt_r > PEAK_CYC)
               peak_fired_r <= 1'b1;
         end
         // mask writes; reserved bits stay zero
         if (wr_stb_r && ptr_r == `CSE_OFS_MASK_SUPPLY)
            mask_sup_r <= wr_data_r & 8'hF8;
         if (wr_stb_r && ptr_r == `CSE_OFS_MASK_PROT)
            mask_prot_r <= wr_data_r;
         if (wr_stb_r && ptr_r == `CSE_OFS_MASK_TIMERS)
            mask_tim_r <= wr_data_r & `CSE_TIMERS_USED;
         // single conversion start; upper bits of the write ignored
         o_adc_start <= wr_stb_r && ptr_r == `CSE_OFS_ADC_CONTROL
                        && wr_data_r[`CSE_BIT_SINGLE_CONV];
         // zero mask lets the event through
         o_irq <= |(ev_sup_nxt & ~mask_sup_r & 8'hF8)
                | |(ev_prot_nxt & ~mask_prot_r)
                | |(ev_tim_nxt & ~mask_tim_r & `CSE_TIMERS_USED);
      end
   end

endmodule

`default_nettype wire

// ===== tb/cse_checker.sv
// cse_checker.sv: port assertions for the status, event and mask block.
// assumes binding to cse_status_event; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module cse_checker (
   input wire logic       i_clock,
   input wire logic       i_rst_b,
   input wire logic       i_scl,
   input wire logic [4:0] i_supply_flags,
   input wire logic       o_sda_oe,
   input wire logic       o_sda_out,
   input wire logic       o_adc_start,
   input wire logic       o_irq
);
   logic quiet_r;

   default clocking cb @(posedge i_clock); endclocking

   // no bus traffic since reset: masks still at reset values
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
         quiet_r <= 1'b1;
      else if (!i_scl)
         quiet_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   irq_reset_a: assert property (!i_rst_b |=> !o_irq)
      else $error("irq high after reset edge");
   outs_reset_a: assert property (!i_rst_b |=> !o_adc_start && !o_sda_oe)
      else $error("outputs active after reset edge");
   sda_low_a: assert property (disable iff (!i_rst_b) o_sda_oe |-> !o_sda_out)
      else $error("data pin driven high");
   adc_pulse_a: assert property (disable iff (!i_rst_b) o_adc_start |=> !o_adc_start)
      else $error("conversion start longer than one cycle");
   quiet_adc_a: assert property (disable iff (!i_rst_b) quiet_r |-> !o_adc_start)
      else $error("conversion start without a write");
   oe_change_a: assert property (disable iff (!i_rst_b) $changed(o_sda_oe) |-> !i_scl)
      else $error("data pin changed while clock high");
   quiet_oe_a: assert property (disable iff (!i_rst_b) quiet_r |-> !o_sda_oe)
      else $error("data pin driven with idle bus");
   adaptor_irq_a: assert property (disable iff (!i_rst_b)
      quiet_r && $changed(i_supply_flags[0]) |-> ##[2:8] o_irq)
      else $error("adaptor change gave no interrupt");
   irq_hold_a: assert property (disable iff (!i_rst_b) quiet_r && o_irq |=> o_irq)
      else $error("interrupt dropped without a clear");
endmodule

`default_nettype wire

// ===== tb/cse_host_model.sv
// cse_host_model.sv: 2-wire bus master standing in for the host.
// assumes an open-drain data line with pull-up built by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "cse_map.vh"

module cse_host_model (
   input  wire logic i_clock,
   input  wire logic i_sda,
   output var logic  o_scl,
   output var logic  o_sda_low
);
   // idle bus: clock high, data released
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic half(input logic c);
      begin
         repeat (9) @(negedge i_clock);
         o_scl = c;
      end
   endtask

   task automatic put_bit(input logic b);
      begin
         repeat (3) @(negedge i_clock);
         o_sda_low = !b;
         half(1'b1);
         half(1'b0);
      end
   endtask

   // released line, sampled as the clock goes high
   task automatic get_bit(output logic b);
      begin
         repeat (3) @(negedge i_clock);
         o_sda_low = 1'b0;
         half(1'b1);
         b = i_sda;
         half(1'b0);
      end
   endtask

   task automatic start;
      begin
         repeat (3) @(negedge i_clock);
         o_sda_low = 1'b0;
         half(1'b1);
         repeat (9) @(negedge i_clock);
         o_sda_low = 1'b1;
         half(1'b0);
      end
   endtask

   task automatic stop;
      begin
         repeat (3) @(negedge i_clock);
         o_sda_low = 1'b1;
         half(1'b1);
         repeat (9) @(negedge i_clock);
         o_sda_low = 1'b0;
         repeat (9) @(negedge i_clock);
      end
   endtask

   task automatic put_byte(input logic [7:0] d, inout logic nack);
      logic   b;
      integer k;
      begin
         for (k = 7; k >= 0; k--)
            put_bit(d[k]);
         get_bit(b);
         nack = nack | b;
      end
   endtask

   // pointer then one data byte
   task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                     output logic nack);
      begin
         nack = 1'b0;
         start;
         put_byte({dev, 1'b0}, nack);
         put_byte(ofs, nack);
         put_byte(d, nack);
         stop;
      end
   endtask

   // pointer, repeated start, one byte ended by a nack
   task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
      logic   nack;
      logic   b;
      integer k;
      begin
         nack = 1'b0;
         start;
         put_byte({`CSE_DEV_ADDR, 1'b0}, nack);
         put_byte(ofs, nack);
         start;
         put_byte({`CSE_DEV_ADDR, 1'b1}, nack);
         for (k = 7; k >= 0; k--)
         begin
            get_bit(b);
            d[k] = b;
         end
         put_bit(1'b1);
         stop;
      end
   endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// testbench.sv: self-checking bench for the status, event and mask block.
// assumes cse_host_model as bus master and cse_checker bound to cse_status_event.
`timescale 1ns/1ps
`default_nettype none
`include "cse_map.vh"

module testbench;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [4:0]  sup = 5'h0;
   logic [7:0]  prot = 8'h00;
   logic [2:0]  st = 3'h0;
   logic        peak = 1'b0;
   logic [3:0]  pulse = 4'h0;
   logic        scl, sda_low, sda_oe, sda_out, adc_start, irq, ack_bad;
   wire         sda_line = !(sda_oe || sda_low);
   logic [7:0]  ev_a = 8'h00, ev_b = 8'h00, ev_c = 8'h00, val;
   logic [7:0]  m_a = `CSE_RST_MASK_SUPPLY, m_b = `CSE_RST_MASK_PROT, m_c = `CSE_RST_MASK_TIMERS;
   logic [31:0] r1;
   logic [2:0]  states [4] = '{`CSE_STATE_SHUTDOWN, `CSE_STATE_IDLE,
                                `CSE_STATE_LOW_POWER, `CSE_STATE_ACTIVE};
   integer      seed = 35146, bad_count = 0, num_checks = 0, cycles = 0, starts = 0, i;

   cse_status_event DUT (
      .i_clock(clock), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_line),
      .o_sda_oe(sda_oe), .o_sda_out(sda_out), .i_supply_flags(sup),
      .i_prot_flags(prot), .i_peak_over(peak), .i_op_state(st),
      .i_adc_done(pulse[3]), .i_safety_expired(pulse[2]),
      .i_soft_timer_expired(pulse[1]), .i_temp_poweron(pulse[0]),
      .o_adc_start(adc_start), .o_irq(irq));

   cse_host_model host (.i_clock(clock), .i_sda(sda_line), .o_scl(scl), .o_sda_low(sda_low));

   always #20 clock = !clock;

   // cycle ceiling and conversion start count
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (adc_start === 1'b1)
         starts = starts + 1;
      if (cycles == 80000)
      begin
         bad_count = bad_count + 1;
         final_report;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp)
         begin
            bad_count = bad_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
      begin
         host.rd(ofs, val);
         check(val, exp);
         check({7'h0, irq}, {7'h0, |((ev_a & ~m_a) | (ev_b & ~m_b) | (ev_c & ~m_c))});
      end
   endtask

   task automatic wrc(input logic [7:0] ofs, input logic [7:0] d);
      begin
         host.wr(`CSE_DEV_ADDR, ofs, d, ack_bad);
         check({7'h0, ack_bad}, 8'h00);
      end
   endtask

   // new flag levels; any change latches its event
   task automatic drive(input logic [4:0] s, input logic [7:0] p, input logic [2:0] c);
      begin
         @(negedge clock);
         ev_a = ev_a | {s ^ sup, 3'h0};
         ev_b = ev_b | (p ^ prot);
         sup = s;
         prot = p;
         st = c;
         repeat (10) @(negedge clock);
      end
   endtask

   task automatic final_report;
      begin
         $display("checks %0d mismatches %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      repeat (6) @(negedge clock);
      drive(5'h01, 8'h00, `CSE_STATE_IDLE);
      rdc(`CSE_OFS_MASK_SUPPLY, `CSE_RST_MASK_SUPPLY);
      rdc(`CSE_OFS_MASK_PROT, `CSE_RST_MASK_PROT);
      rdc(`CSE_OFS_MASK_TIMERS, `CSE_RST_MASK_TIMERS);
      rdc(8'h09, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         r1 = $random(seed);
         drive(r1[4:0], r1[15:8], states[i]);
         rdc(`CSE_OFS_STATUS_SUPPLY, {sup, st});
         rdc(`CSE_OFS_STATUS_PROT, prot);
         rdc(`CSE_OFS_EVENT_SUPPLY, ev_a);
         rdc(`CSE_OFS_EVENT_PROT, ev_b);
      end
      drive(sup, prot, 3'h3);
      rdc(`CSE_OFS_STATUS_SUPPLY, {sup, `CSE_STATE_ACTIVE});
      r1 = $random(seed);
      wrc(`CSE_OFS_EVENT_PROT, r1[7:0]);
      ev_b = ev_b & ~r1[7:0];
      rdc(`CSE_OFS_EVENT_PROT, ev_b);
      wrc(`CSE_OFS_EVENT_SUPPLY, 8'h00);
      wrc(`CSE_OFS_STATUS_PROT, 8'hFF);
      rdc(`CSE_OFS_STATUS_PROT, prot);
      rdc(`CSE_OFS_EVENT_SUPPLY, ev_a);
      wrc(`CSE_OFS_MASK_SUPPLY, r1[23:16]);
      m_a = r1[23:16] & 8'hF8;
      wrc(`CSE_OFS_MASK_PROT, r1[31:24]);
      m_b = r1[31:24];
      wrc(`CSE_OFS_MASK_TIMERS, 8'hE0);
      m_c = 8'h00;
      rdc(`CSE_OFS_MASK_SUPPLY, m_a);
      rdc(`CSE_OFS_MASK_PROT, m_b);
      rdc(`CSE_OFS_MASK_TIMERS, m_c);
      for (i = 0; i < 4; i++)
      begin
         @(negedge clock);
         pulse = 4'h1 << i;
         @(negedge clock);
         pulse = 4'h0;
      end
      ev_c = 8'h1D;
      rdc(`CSE_OFS_EVENT_TIMERS, ev_c);
      @(negedge clock);
      peak = 1'b1;
      repeat (20) @(negedge clock);
      peak = 1'b0;
      rdc(`CSE_OFS_EVENT_TIMERS, ev_c);
      peak = 1'b1;
      repeat (40) @(negedge clock);
      peak = 1'b0;
      ev_c = 8'h1F;
      rdc(`CSE_OFS_EVENT_TIMERS, ev_c);
      wrc(`CSE_OFS_EVENT_TIMERS, 8'hFF);
      ev_c = 8'h01;
      rdc(`CSE_OFS_EVENT_TIMERS, ev_c);
      wrc(`CSE_OFS_ADC_CONTROL, 8'hF1);
      wrc(`CSE_OFS_ADC_CONTROL, 8'hFE);
      check(starts[7:0], 8'h01);
      host.wr(7'h5A, `CSE_OFS_MASK_SUPPLY, 8'h00, ack_bad);
      check({7'h0, ack_bad}, 8'h01);
      rdc(`CSE_OFS_MASK_SUPPLY, m_a);
      drive(5'h00, 8'h00, `CSE_STATE_SHUTDOWN);
      rst_b = 1'b0;
      repeat (4) @(negedge clock);
      rst_b = 1'b1;
      repeat (6) @(negedge clock);
      ev_a = 8'h00;
      ev_b = 8'h00;
      ev_c = 8'h00;
      m_a = `CSE_RST_MASK_SUPPLY;
      m_b = `CSE_RST_MASK_PROT;
      m_c = `CSE_RST_MASK_TIMERS;
      rdc(`CSE_OFS_EVENT_TIMERS, 8'h00);
      final_report;
   end
endmodule

bind cse_status_event cse_checker u_chk (
   .i_clock(i_clock), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_supply_flags(i_supply_flags),
   .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out), .o_adc_start(o_adc_start), .o_irq(o_irq));

`default_nettype wire
